// ### hw/wdt_pkg.sv
// constants and types for the watchdog reset and fetch trap block
`default_nettype none
package wdt_pkg;
   // register indices as printed, byte address is four times the index
   localparam logic [7:0] CTL_ONE_IDX = 8'h34;
   localparam logic [7:0] CODE_IDX = 8'h35;
   localparam logic [7:0] CTL_ONE_ADDR = 8'(CTL_ONE_IDX * 4);
   localparam logic [7:0] CODE_ADDR = 8'(CODE_IDX * 4);
   localparam logic [7:0] IRQ_STATUS_ADDR = 8'he0;
   localparam logic [7:0] IRQ_CLEAR_ADDR = 8'he4;
   localparam logic [7:0] IRQ_ENABLE_ADDR = 8'he8;
   localparam logic [7:0] STATE_ADDR = 8'hec;
   // control one field positions
   localparam int ACT_SEL_BIT = 0;
   localparam int DET_LO_BIT = 1;
   localparam int DET_HI_BIT = 2;
   localparam int EN_BIT = 3;
   localparam int TRAP_SEL_BIT = 4;
   localparam int RAM_TRAP_BIT = 5;
   localparam logic [5:0] CTL_ONE_RESET = 6'h39;
   // code port values
   localparam logic [7:0] CODE_TRAP_AREA = 8'hd2;
   localparam logic [7:0] CODE_CLEAR = 8'h4e;
   localparam logic [7:0] CODE_DISABLE = 8'hb1;
   // interrupt status bit positions
   localparam int EV_WDT_OVF = 0;
   localparam int EV_FETCH_TRAP = 1;
   localparam int EV_RESET = 2;
   localparam int EV_W = 3;
   // reset pulse length: 24 fast clock periods at the block clock rate
   localparam longint CLK_HZ = 40000000;
   localparam longint FAST_CLK_HZ = 40000000;
   localparam longint RST_FC_PERIODS = 24;
   localparam int RST_CYC_RAW = int'((RST_FC_PERIODS * CLK_HZ) / FAST_CLK_HZ);
   localparam int RST_CYC = (RST_CYC_RAW < 1) ? 1 : RST_CYC_RAW;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef struct packed {
      logic valid;
      logic [15:0] addr;
   } wdt_fetch_t;
   typedef struct packed {
      logic fetch_trap;
      logic wdt_overflow;
   } wdt_nmi_t;
   typedef enum logic [1:0] {ACT_NONE, ACT_IRQ, ACT_RESET} wdt_action_t;
endpackage : wdt_pkg
`default_nettype wire

// ### hw/wdt_top.sv
// watchdog overflow action, fetch address trap and reset pulse, axi4-lite slave
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none
module wdt_top #(
   parameter int DET_EXP_0 = 25,
   parameter int DET_EXP_1 = 23,
   parameter int DET_EXP_2 = 21,
   parameter int DET_EXP_3 = 19,
   parameter logic [15:0] SFR_LO = 16'h0000,
   parameter logic [15:0] SFR_HI = 16'h003f,
   parameter logic [15:0] RAM_LO = 16'h0040,
   parameter logic [15:0] RAM_HI = 16'h023f,
   parameter logic [15:0] DBR_LO = 16'h0f80,
   parameter logic [15:0] DBR_HI = 16'h0fff
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire wdt_pkg::wdt_fetch_t fetch,
   input wire wdt_pkg::wdt_nmi_t nmi_ack,
   input wire logic low_speed_mode_one,
   output wdt_pkg::wdt_nmi_t nmi_req,
   output logic reset_pin_n,
   output logic internal_reset,
   output logic hf_osc_restart,
   output logic irq
);
   import wdt_pkg::*;

   localparam int CNT_W = 26;

   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   function automatic logic [CNT_W-1:0] det_last(input logic [1:0] sel);
      int e;
      unique case (sel)
         2'b00: e = DET_EXP_0;
         2'b01: e = DET_EXP_1;
         2'b10: e = DET_EXP_2;
         2'b11: e = DET_EXP_3;
      endcase
      det_last = CNT_W'((64'd1 << e) - 64'd1);
   endfunction : det_last

   // bus state
   logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic wstrb0_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;

   // control state
   logic act_sel_q, en_q, en_wr_q, trap_sel_q, ram_pend_q, ram_act_q;
   logic [1:0] det_q;
   logic [CNT_W-1:0] cnt_q;
   logic [EV_W-1:0] ev_stat_q, ev_en_q;
   logic [$clog2(RST_CYC+1)-1:0] rst_cnt_q;
   logic reset_pin_n_q, internal_reset_q, hf_osc_restart_q, irq_q;
   wdt_nmi_t nmi_q;

   logic do_wr, wr_ctl, wr_code, wr_clr, wr_en, ctl_rst;
   logic [7:0] wbyte;
   logic overflow, trap_hit;
   wdt_action_t wdt_act, trap_act;
   logic rst_req;
   logic [EV_W-1:0] ev_set;

   // both address and data held, response not yet given
   assign do_wr = !awready_q && !wready_q && !bvalid_q;
   assign wbyte = wdata_q[7:0];
   assign wr_ctl = do_wr && wstrb0_q && (awaddr_q == CTL_ONE_ADDR);
   assign wr_code = do_wr && wstrb0_q && (awaddr_q == CODE_ADDR);
   assign wr_clr = do_wr && wstrb0_q && (awaddr_q == IRQ_CLEAR_ADDR);
   assign wr_en = do_wr && wstrb0_q && (awaddr_q == IRQ_ENABLE_ADDR);
   // the pulse on the reset pin also returns the control one fields, enables and counter to their reset values
   assign ctl_rst = reset || (rst_cnt_q != '0);

   // write channels, taken in either order
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         awready_q <= 1'b1;
         wready_q <= 1'b1;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb0_q <= 1'b0;
      end else begin
         if (s_axi_awvalid && awready_q) begin
            awready_q <= 1'b0;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_q) begin
            wready_q <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (bvalid_q && s_axi_bready) begin
            awready_q <= 1'b1;
            wready_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_wr) begin
         bvalid_q <= 1'b1;
         unique case (awaddr_q)
            CTL_ONE_ADDR, CODE_ADDR, IRQ_CLEAR_ADDR, IRQ_ENABLE_ADDR,
            IRQ_STATUS_ADDR, STATE_ADDR: bresp_q <= RESP_OKAY;
            default: bresp_q <= RESP_SLVERR;
         endcase
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // read channel, answer one cycle after the address is taken
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         arready_q <= 1'b1;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (s_axi_arvalid && arready_q) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
         unique case (s_axi_araddr)
            // write-only ports read as zero
            CTL_ONE_ADDR, CODE_ADDR, IRQ_CLEAR_ADDR: rdata_q <= '0;
            IRQ_STATUS_ADDR: rdata_q <= 32'(ev_stat_q);
            IRQ_ENABLE_ADDR: rdata_q <= 32'(ev_en_q);
            STATE_ADDR: rdata_q <= {26'h0, ram_act_q, ram_pend_q, trap_sel_q,
                                    en_q, det_q[1], act_sel_q};
            default: rresp_q <= RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end
   end

   // control one fields
   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         act_sel_q <= CTL_ONE_RESET[ACT_SEL_BIT];
         det_q <= CTL_ONE_RESET[DET_HI_BIT:DET_LO_BIT];
         trap_sel_q <= CTL_ONE_RESET[TRAP_SEL_BIT];
         ram_pend_q <= CTL_ONE_RESET[RAM_TRAP_BIT];
      end else if (wr_ctl) begin
         // action select can only be lowered by software
         act_sel_q <= act_sel_q && wbyte[ACT_SEL_BIT];
         det_q <= wbyte[DET_HI_BIT:DET_LO_BIT];
         trap_sel_q <= wbyte[TRAP_SEL_BIT];
         ram_pend_q <= wbyte[RAM_TRAP_BIT];
      end
   end

   // enable: set by control one, cleared only by disable code while bit is low
   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         en_q <= CTL_ONE_RESET[EN_BIT];
      end else if (wr_ctl && wbyte[EN_BIT]) begin
         en_q <= 1'b1;
      end else if (wr_code && (wbyte == CODE_DISABLE) && !en_wr_q) begin
         en_q <= 1'b0;
      end
   end

   // pending enable-bit value kept apart so the disable code sees the written value
   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         en_wr_q <= CTL_ONE_RESET[EN_BIT];
      end else if (wr_ctl) begin
         en_wr_q <= wbyte[EN_BIT];
      end
   end

   logic run_q;
   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         run_q <= CTL_ONE_RESET[EN_BIT];
      end else if (wr_ctl && wbyte[EN_BIT]) begin
         run_q <= 1'b1;
      end else if (wr_code && (wbyte == CODE_DISABLE) && !en_wr_q) begin
         run_q <= 1'b0;
      end
   end

   // ram trap enable only applied by the trap area code
   always_ff @(posedge ref_clk) begin
      if (ctl_rst) begin
         ram_act_q <= CTL_ONE_RESET[RAM_TRAP_BIT];
      end else if (wr_code && (wbyte == CODE_TRAP_AREA)) begin
         ram_act_q <= ram_pend_q;
      end
   end

   // binary counter; held clear while disabled
   assign overflow = run_q && (cnt_q == det_last(det_q));
   always_ff @(posedge ref_clk) begin
      if (ctl_rst || !run_q) begin
         cnt_q <= '0;
      end else if (wr_code && (wbyte == CODE_CLEAR)) begin
         cnt_q <= '0;
      end else if (overflow) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + CNT_W'(1);
      end
   end

   // overflow action
   always_comb begin
      wdt_act = ACT_NONE;
      if (overflow) begin
         wdt_act = act_sel_q ? ACT_RESET : ACT_IRQ;
      end
   end

   // fetch trap detection, combinational in the fetch cycle
   assign trap_hit = fetch.valid && !ctl_rst
      && ((ram_act_q && in_range(fetch.addr, RAM_LO, RAM_HI))
         || in_range(fetch.addr, SFR_LO, SFR_HI)
         || in_range(fetch.addr, DBR_LO, DBR_HI));
   always_comb begin
      trap_act = ACT_NONE;
      if (trap_hit) begin
         trap_act = trap_sel_q ? ACT_RESET : ACT_IRQ;
      end
   end

   assign rst_req = (wdt_act == ACT_RESET) || (trap_act == ACT_RESET);

   // non-maskable requests: the global mask flag is not consulted, and a new
   // trap re-raises the request even while an earlier one is in service
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         nmi_q <= '0;
      end else begin
         if (trap_act == ACT_IRQ) begin
            nmi_q.fetch_trap <= 1'b1;
         end else if (nmi_ack.fetch_trap) begin
            nmi_q.fetch_trap <= 1'b0;
         end
         if (wdt_act == ACT_IRQ) begin
            nmi_q.wdt_overflow <= 1'b1;
         end else if (nmi_ack.wdt_overflow) begin
            nmi_q.wdt_overflow <= 1'b0;
         end
      end
   end

   // reset pulse on the pin and to internal logic
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         rst_cnt_q <= '0;
         reset_pin_n_q <= 1'b1;
         internal_reset_q <= 1'b0;
      end else if (rst_req) begin
         rst_cnt_q <= ($bits(rst_cnt_q))'(RST_CYC);
         reset_pin_n_q <= 1'b0;
         internal_reset_q <= 1'b1;
      end else if (rst_cnt_q > ($bits(rst_cnt_q))'(1)) begin
         rst_cnt_q <= rst_cnt_q - ($bits(rst_cnt_q))'(1);
      end else begin
         rst_cnt_q <= '0;
         reset_pin_n_q <= 1'b1;
         internal_reset_q <= 1'b0;
      end
   end

   // slow mode has the fast oscillator stopped, so restart it with the reset
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         hf_osc_restart_q <= 1'b0;
      end else begin
         hf_osc_restart_q <= rst_req && low_speed_mode_one;
      end
   end

   // interrupt status, enable and level output; a set beats a clear
   assign ev_set = {rst_req, trap_act == ACT_IRQ, wdt_act == ACT_IRQ};
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ev_stat_q <= '0;
         ev_en_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ev_stat_q <= (ev_stat_q & ~(wr_clr ? wdata_q[EV_W-1:0] : '0)) | ev_set;
         if (wr_en) begin
            ev_en_q <= wdata_q[EV_W-1:0];
         end
         irq_q <= |(((ev_stat_q & ~(wr_clr ? wdata_q[EV_W-1:0] : '0)) | ev_set)
                    & (wr_en ? wdata_q[EV_W-1:0] : ev_en_q));
      end
   end

   assign s_axi_awready = awready_q;
   assign s_axi_wready = wready_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = arready_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign nmi_req = nmi_q;
   assign reset_pin_n = reset_pin_n_q;
   assign internal_reset = internal_reset_q;
   assign hf_osc_restart = hf_osc_restart_q;
   assign irq = irq_q;
endmodule : wdt_top
`default_nettype wire

// ### verification/wdt_props.sv
// port assertions for the watchdog reset and fetch trap block
`default_nettype none
module wdt_props #(
   parameter logic [15:0] SFR_LO = 16'h0000,
   parameter logic [15:0] SFR_HI = 16'h003f,
   parameter logic [15:0] DBR_LO = 16'h0f80,
   parameter logic [15:0] DBR_HI = 16'h0fff
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire wdt_pkg::wdt_fetch_t fetch,
   input wire wdt_pkg::wdt_nmi_t nmi_ack,
   input wire logic low_speed_mode_one,
   input wire wdt_pkg::wdt_nmi_t nmi_req,
   input wire logic reset_pin_n,
   input wire logic internal_reset,
   input wire logic hf_osc_restart
);
   import wdt_pkg::*;
   logic [7:0] low_q;
   logic hit;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // counts sampled low cycles so the pulse length is checked exactly
   always_ff @(posedge ref_clk) begin
      if (reset || reset_pin_n)
         low_q <= 8'h00;
      else
         low_q <= low_q + 8'h01;
   end
   assign hit = fetch.valid && ((fetch.addr >= SFR_LO && fetch.addr <= SFR_HI) ||
      (fetch.addr >= DBR_LO && fetch.addr <= DBR_HI));
   a_pin_inverse: assert property (internal_reset == !reset_pin_n)
      else $error("internal reset not inverse of reset pin");
   a_pulse_len: assert property ($rose(reset_pin_n) |-> low_q == RST_CYC)
      else $error("reset pulse length wrong");
   a_pulse_max: assert property (!reset_pin_n |-> low_q < RST_CYC)
      else $error("reset pulse too long");
   a_area_trap: assert property (hit && reset_pin_n |=> nmi_req.fetch_trap || !reset_pin_n)
      else $error("area fetch gave no trap");
   a_osc_pulse: assert property (hf_osc_restart |=> !hf_osc_restart)
      else $error("oscillator restart longer than one cycle");
   a_osc_with_reset: assert property ($fell(reset_pin_n) && low_speed_mode_one
      |-> hf_osc_restart || $past(hf_osc_restart))
      else $error("no oscillator restart with reset in low speed mode");
   a_trap_hold: assert property (nmi_req.fetch_trap && !nmi_ack.fetch_trap
      |=> nmi_req.fetch_trap)
      else $error("trap request dropped before accept");
   a_wdt_hold: assert property (nmi_req.wdt_overflow && !nmi_ack.wdt_overflow
      |=> nmi_req.wdt_overflow)
      else $error("overflow request dropped before accept");
   cover property ($rose(reset_pin_n));
   cover property ($rose(nmi_req.fetch_trap));
   cover property ($rose(nmi_req.wdt_overflow));
   cover property (hf_osc_restart);
endmodule : wdt_props
bind wdt_top wdt_props #(.SFR_LO(SFR_LO), .SFR_HI(SFR_HI), .DBR_LO(DBR_LO), .DBR_HI(DBR_HI))
   u_props (.ref_clk(ref_clk), .reset(reset), .fetch(fetch), .nmi_ack(nmi_ack),
   .low_speed_mode_one(low_speed_mode_one), .nmi_req(nmi_req), .reset_pin_n(reset_pin_n),
   .internal_reset(internal_reset), .hf_osc_restart(hf_osc_restart));
`default_nettype wire

// ### verification/wdt_cpu_model.sv
// cpu core model: issues opcode fetches and accepts non-maskable requests
`default_nettype none
module wdt_cpu_model (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic fetch_go,
   input wire logic [15:0] fetch_go_addr,
   input wire logic [7:0] ack_dly,
   input wire wdt_pkg::wdt_nmi_t nmi_req,
   output wdt_pkg::wdt_fetch_t fetch,
   output wdt_pkg::wdt_nmi_t nmi_ack
);
   import wdt_pkg::*;
   logic [7:0] cnt_q [2];
   always_ff @(posedge ref_clk) begin
      fetch.valid <= fetch_go & ~reset;
      // idle address toggles between the last fetch address and its inverse; fetch.valid stays low so it never traps
      fetch.addr <= reset ? 16'h5a5a : (fetch_go ? fetch_go_addr : ~fetch.addr);
   end
   // each request is accepted with a one-cycle ack once it has waited ack_dly cycles, with no check on a newer request
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 2; i++) begin
         nmi_ack[i] <= 1'b0;
         if (reset) begin
            cnt_q[i] <= 8'h00;
         end else if (nmi_req[i] && !nmi_ack[i]) begin
            if (cnt_q[i] >= ack_dly) begin
               nmi_ack[i] <= 1'b1;
               cnt_q[i] <= 8'h00;
            end else begin
               cnt_q[i] <= cnt_q[i] + 8'h01;
            end
         end
      end
   end
endmodule : wdt_cpu_model
`default_nettype wire

// ### verification/testbench.sv
// bench: drives the bus and cpu model, compares with an integer model
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import wdt_pkg::*;
   logic ref_clk = 1'b0, reset = 1'b1, low_speed_mode_one = 1'b0, fetch_go = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ack_dly = 8'h02;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic reset_pin_n, internal_reset, hf_osc_restart, irq;
   logic [15:0] fetch_go_addr = 16'h0;
   wdt_fetch_t fetch;
   wdt_nmi_t nmi_ack, nmi_req;
   int mismatches = 0, checked = 0, n, hf, k;
   int m_act = 1, m_det = 0, m_trap = 1, m_pend = 1, m_actv = 1, m_stat = 0;
   int m_en = 1, m_enw = 1;
   int ta [8] = '{16'h0010, 16'h003f, 16'h0f80, 16'h0fff, 16'h0240, 16'h1000, 0, 0};
   wdt_top #(.DET_EXP_0(8), .DET_EXP_1(7), .DET_EXP_2(6), .DET_EXP_3(5)) dut_u (
      .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .fetch(fetch), .nmi_ack(nmi_ack),
      .low_speed_mode_one(low_speed_mode_one), .nmi_req(nmi_req),
      .reset_pin_n(reset_pin_n), .internal_reset(internal_reset),
      .hf_osc_restart(hf_osc_restart), .irq(irq));
   wdt_cpu_model cpu_u (.ref_clk(ref_clk), .reset(reset), .fetch_go(fetch_go),
      .fetch_go_addr(fetch_go_addr), .ack_dly(ack_dly), .nmi_req(nmi_req),
      .fetch(fetch), .nmi_ack(nmi_ack));
   initial forever #12.5 ref_clk = ~ref_clk;
   task automatic end_sim;
      if (mismatches == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_t, w_t, b_t;
      logic [1:0] br;
      @(posedge ref_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         aw_t = s_axi_awvalid & s_axi_awready;
         w_t = s_axi_wvalid & s_axi_wready;
         b_t = s_axi_bvalid;
         br = s_axi_bresp;
         @(posedge ref_clk);
         if (aw_t) s_axi_awvalid <= 1'b0;
         if (w_t) s_axi_wvalid <= 1'b0;
         if (b_t) begin
            s_axi_bready <= 1'b0;
            check(br, er);
            return;
         end
      end
      mismatches++;
      end_sim();
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, input logic [1:0] er);
      logic ar_t, r_t;
      logic [1:0] rr;
      @(posedge ref_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         @(negedge ref_clk);
         ar_t = s_axi_arvalid & s_axi_arready;
         r_t = s_axi_rvalid;
         rr = s_axi_rresp;
         rd = s_axi_rdata;
         @(posedge ref_clk);
         if (ar_t) s_axi_arvalid <= 1'b0;
         if (r_t) begin
            s_axi_rready <= 1'b0;
            check(rr, er);
            return;
         end
      end
      mismatches++;
      end_sim();
   endtask : axi_rd
   // model: action select can only be cleared, ram trap waits for the area code
   task automatic wr_ctl(input int v);
      axi_wr(CTL_ONE_ADDR, 32'(v), RESP_OKAY);
      m_act = m_act & v;
      m_det = (v >> 1) & 3;
      m_trap = (v >> 4) & 1;
      m_pend = (v >> 5) & 1;
      m_enw = (v >> 3) & 1;
      if (m_enw == 1) m_en = 1;
   endtask : wr_ctl
   task automatic wr_code(input int v);
      axi_wr(CODE_ADDR, 32'(v), RESP_OKAY);
      if (v == CODE_TRAP_AREA) m_actv = m_pend;
      if (v == CODE_DISABLE && m_enw == 0) m_en = 0;
   endtask : wr_code
   task automatic m_rst;
      m_act = 1;
      m_det = 0;
      m_trap = 1;
      m_pend = 1;
      m_actv = 1;
      m_en = 1;
      m_enw = 1;
      m_stat = m_stat | 4;
   endtask : m_rst
   task automatic chk_state;
      axi_rd(STATE_ADDR, RESP_OKAY);
      check(rd & 32'h3f, 32'(m_act | ((m_det >> 1) << 1) | (m_en << 2) | (m_trap << 3) |
         (m_pend << 4) | (m_actv << 5)));
   endtask : chk_state
   task automatic do_fetch(input logic [15:0] a, input logic e);
      @(posedge ref_clk);
      fetch_go <= 1'b1;
      fetch_go_addr <= a;
      @(posedge ref_clk);
      fetch_go <= 1'b0;
      if (e) m_stat = m_stat | 2;
      repeat (2) @(negedge ref_clk);
      check(nmi_req.fetch_trap, e);
      repeat (10) @(posedge ref_clk);
   endtask : do_fetch
   task automatic wait_pulse;
      n = 0;
      hf = 0;
      for (int i = 0; i < 700; i++) begin
         @(negedge ref_clk);
         if (hf_osc_restart === 1'b1) hf = 1;
         if (reset_pin_n === 1'b0) n++;
         else if (n > 0) return;
      end
      mismatches++;
      end_sim();
   endtask : wait_pulse
   initial begin
      k = $urandom(32'hd24b035b);
      ta[6] = 16'h0040 + $urandom % 512;
      ta[7] = 16'h0040 + $urandom % 512;
      repeat (6) @(posedge ref_clk);
      reset <= 1'b0;
      chk_state();
      axi_rd(CTL_ONE_ADDR, RESP_OKAY);
      check(rd, 32'h0);
      axi_rd(8'hf0, RESP_SLVERR);
      axi_wr(8'hf4, 32'h0, RESP_SLVERR);
      wait_pulse();
      check(n, RST_CYC);
      check(hf, 0);
      m_rst();
      axi_wr(IRQ_ENABLE_ADDR, 32'h7, RESP_OKAY);
      axi_rd(IRQ_STATUS_ADDR, RESP_OKAY);
      check(rd & 32'h7, m_stat);
      check(irq, 1'b1);
      axi_wr(IRQ_CLEAR_ADDR, 32'h4, RESP_OKAY);
      m_stat = 0;
      repeat (3) @(negedge ref_clk);
      check(irq, 1'b0);
      wr_code(CODE_CLEAR);
      wr_ctl(6);
      wr_code(CODE_DISABLE);
      k = $urandom & 8'hff;
      if (k == CODE_TRAP_AREA || k == CODE_CLEAR || k == CODE_DISABLE) k = k ^ 1;
      wr_code(k);
      wr_ctl(7);
      chk_state();
      repeat (300) @(posedge ref_clk);
      check(reset_pin_n, 1'b1);
      // action select is already 0, so a running counter would only show as status bit 0
      axi_rd(IRQ_STATUS_ADDR, RESP_OKAY);
      check(rd & 32'h7, m_stat);
      do_fetch(16'h0100, 1'b1);
      wr_code(CODE_TRAP_AREA);
      chk_state();
      for (int i = 0; i < 8; i++) do_fetch(16'(ta[i]), i < 4);
      axi_rd(IRQ_STATUS_ADDR, RESP_OKAY);
      check(rd & 32'h7, m_stat);
      check(irq, 1'b1);
      wr_ctl(8'h0e);
      for (k = 0; k < 300 && nmi_req.wdt_overflow !== 1'b1; k++) @(negedge ref_clk);
      check(nmi_req.wdt_overflow, 1'b1);
      check(reset_pin_n, 1'b1);
      if (k == 300) end_sim();
      m_stat = m_stat | 1;
      wr_code(CODE_CLEAR);
      wr_ctl(6);
      wr_code(CODE_DISABLE);
      axi_rd(IRQ_STATUS_ADDR, RESP_OKAY);
      check(rd & 32'h7, m_stat);
      low_speed_mode_one <= 1'b1;
      wr_ctl(8'h16);
      @(posedge ref_clk);
      fetch_go <= 1'b1;
      fetch_go_addr <= 16'h0f88;
      @(posedge ref_clk);
      fetch_go <= 1'b0;
      wait_pulse();
      check(n, RST_CYC);
      check(hf, 1);
      check(nmi_req.fetch_trap, 1'b0);
      m_rst();
      chk_state();
      end_sim();
   end
   initial begin
      #2000000;
      mismatches++;
      end_sim();
   end
endmodule : testbench
`default_nettype wire
